// ### logic/acs_sequencer.sv
// How it works
// (R1) range bit 1 picks span: 1 gives reference, 0 gives twice reference.
// (R2) lowest control bit picks straight binary or twos complement coding.
// (R3) twelve successive approximation steps give a code of reference over 4096.
// (R4) serial clock runs conversion, shifts result out and control in.
// (R5) each result word is four address bits then twelve result bits.
// (R6) without sequencer the control address field picks one of 16 channels.
// (R7) in sequencer modes each completed transfer moves to the next channel.
// (R8) after mask load, convert lowest selected channel, then next higher ones.
// (R9) after highest mask channel wrap to lowest unless a terminating write.
// (R10) host keeps write bit low or data low while a sequence runs.
// (R11) write with run 1, mask select 0 keeps sequence; others end it.
// (R12) run 1, mask select 1: address is last channel, walk from 0.
// (R13) after last consecutive channel restart at channel 0 if not terminated.
// (R14) mask is 16 bits write only, first bit channel 0, last channel 15.
// (R15) mask loads from transfer right after a write with run 0, select 1.
// (R16) control loads from first 12 data bits only when write bit is 1.
// (R17) twos complement code is straight binary with msb inverted.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer
(
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic [acs_pkg::REG_AW-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [acs_pkg::BUS_W-1:0]     avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [acs_pkg::BUS_W-1:0]     avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          din,
  output logic                               dout,
  output logic                               dout_oe_n,
  input  wire logic                          comparator_above,
  output logic      [acs_pkg::RES_W-1:0]     sar_trial,
  output logic      [acs_pkg::CHAN_W-1:0]    mux_channel,
  output logic                               range_single_ref
);

  // per transfer state, cleared while chip select is high
  typedef struct packed {
    logic [3:0]                   bit_cnt;
    logic                         done;
    logic [acs_pkg::CTRL_W-1:0]   ctrl_shift;
    logic [acs_pkg::NCHAN-1:0]    mask_shift;
    logic [acs_pkg::RES_W-1:0]    trial;
    logic [acs_pkg::RES_W-1:0]    result;
    logic                         dout;
    logic                         dout_oe_n;
  } acs_frame_t;

  // link state that survives between transfers
  typedef struct packed {
    logic                         en_sync1;
    logic                         en_sync2;
    logic [acs_pkg::CTRL_W-1:0]   ctrl;
    logic [acs_pkg::NCHAN-1:0]    mask;
    logic [acs_pkg::CHAN_W-1:0]   chan;
    logic [acs_pkg::CHAN_W-1:0]   last_chan;
    acs_pkg::acs_mode_t           mode;
    logic [acs_pkg::WORD_W-1:0]   snap_word;
    logic                         snap_toggle;
    logic                         range_sel;
  } acs_link_t;

  typedef struct packed {
    logic [2:0]                   tog_sync;
    logic                         link_enable;
    logic                         ack;
    logic                         waitrequest;
    logic [acs_pkg::BUS_W-1:0]    readdata;
    logic [acs_pkg::WORD_W-1:0]   result_word;
    logic [acs_pkg::CTRL_W-1:0]   ctrl_copy;
    logic [acs_pkg::CHAN_W-1:0]   chan_copy;
    logic [acs_pkg::CHAN_W-1:0]   last_copy;
    logic [3:0]                   mode_copy;
    logic [acs_pkg::NCHAN-1:0]    mask_copy;
    logic [15:0]                  frame_count;
  } acs_core_t;

  acs_frame_t frame_reg;
  acs_frame_t frame_next;
  acs_link_t  link_reg;
  acs_link_t  link_next;
  acs_core_t  core_reg;
  acs_core_t  core_next;
  logic       frame_clear;

  function automatic logic [acs_pkg::CHAN_W-1:0] lowest_in_mask
  (
    input logic [acs_pkg::NCHAN-1:0]  m,
    input logic [acs_pkg::CHAN_W-1:0] dflt
  );
    logic [acs_pkg::CHAN_W-1:0] pick;
    pick = dflt;
    for (int i = acs_pkg::NCHAN - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        pick = acs_pkg::CHAN_W'(i);
      end
    end
    return pick;
  endfunction

  function automatic logic [acs_pkg::CHAN_W-1:0] next_in_mask
  (
    input logic [acs_pkg::NCHAN-1:0]  m,
    input logic [acs_pkg::CHAN_W-1:0] cur
  );
    logic [acs_pkg::CHAN_W-1:0] pick;
    logic                       found;
    pick  = cur;
    found = 1'b0;
    for (int i = acs_pkg::NCHAN - 1; i >= 0; i--)
    begin
      if (m[i] && (acs_pkg::CHAN_W'(i) > cur))
      begin
        pick  = acs_pkg::CHAN_W'(i);
        found = 1'b1;
      end
    end
    if (!found)
    begin
      pick = lowest_in_mask(m, cur);
    end
    return pick;
  endfunction

  // ---------------------------------------------------------------- link side
  assign frame_clear = cs_n | ~reset_n;

  logic [3:0]                 pos;
  logic                       dec_bit;
  logic [acs_pkg::RES_W-1:0]  trial_v;
  logic [acs_pkg::RES_W-1:0]  result_v;
  logic [acs_pkg::RES_W-1:0]  coded_v;
  logic [acs_pkg::NCHAN-1:0]  mask_v;
  logic [acs_pkg::CTRL_W-1:0] ctrl_v;
  logic                       last_edge;
  logic                       coding_twos;

  always_comb
  begin
    frame_next  = frame_reg;
    pos         = 4'(acs_pkg::EDGE_LAST - frame_reg.bit_cnt);
    coding_twos = link_reg.ctrl[acs_pkg::CB_CODING];
    trial_v     = frame_reg.trial;
    result_v    = frame_reg.result;
    dec_bit     = comparator_above;
    // (R17) twos complement flips msb
    if (coding_twos && (pos == 4'(acs_pkg::RES_W - 1)))
    begin
      dec_bit = ~comparator_above;
    end
    last_edge = !frame_reg.done && (frame_reg.bit_cnt == acs_pkg::EDGE_LAST);
    ctrl_v    = {frame_reg.ctrl_shift[acs_pkg::CTRL_W-2:0], din};
    mask_v    = {din, frame_reg.mask_shift[acs_pkg::NCHAN-1:1]};
    if (!frame_reg.done)
    begin
      frame_next.dout_oe_n = ~link_reg.en_sync2;
      // (R16) first 12 data bits shift into control
      if (frame_reg.bit_cnt <= acs_pkg::EDGE_CTRL_LAST)
      begin
        frame_next.ctrl_shift = ctrl_v;
      end
      // (R14) first received bit ends at channel 0
      frame_next.mask_shift = mask_v;
      // (R5) address bits go out first
      if (frame_reg.bit_cnt <= acs_pkg::EDGE_ADDR_LAST)
      begin
        frame_next.dout = link_reg.chan[2'(acs_pkg::EDGE_ADDR_LAST - frame_reg.bit_cnt)];
        if (frame_reg.bit_cnt == acs_pkg::EDGE_ADDR_LAST)
        begin
          frame_next.trial = acs_pkg::RES_MSB;
        end
      end
      else
      begin
        // (R3) one approximation step per edge
        trial_v[pos]  = comparator_above;
        result_v[pos] = comparator_above;
        if (pos != 4'h0)
        begin
          trial_v[pos - 4'h1] = 1'b1;
        end
        frame_next.trial  = trial_v;
        frame_next.result = result_v;
        // (R4) result bit leaves on the edge that decides it
        frame_next.dout   = dec_bit;
      end
      frame_next.bit_cnt = frame_reg.bit_cnt + 4'h1;
      frame_next.done    = (frame_reg.bit_cnt == acs_pkg::EDGE_LAST);
    end
    // (R2) coding applied to the reported word
    coded_v = coding_twos ? (result_v ^ acs_pkg::RES_MSB) : result_v;
  end

  always_ff @(posedge sclk or posedge frame_clear)
  begin
    if (frame_clear)
    begin
      frame_reg <= '{bit_cnt: 4'h0, done: 1'b0, ctrl_shift: acs_pkg::CTRL_RESET,
                     mask_shift: acs_pkg::MASK_RESET, trial: acs_pkg::RES_MSB,
                     result: 12'h000, dout: 1'b0, dout_oe_n: 1'b1};
    end
    else
    begin
      frame_reg <= frame_next;
    end
  end

  // sequencer, updated on the last edge of a complete transfer
  always_comb
  begin
    link_next          = link_reg;
    link_next.en_sync1 = core_reg.link_enable;
    link_next.en_sync2 = link_reg.en_sync1;
    if (last_edge && link_reg.en_sync2)
    begin
      link_next.snap_word   = {link_reg.chan, coded_v};
      link_next.snap_toggle = ~link_reg.snap_toggle;
      if (link_reg.mode == acs_pkg::ACS_MODE_MASK_LOAD)
      begin
        // (R15) this transfer carries the mask
        link_next.mask = mask_v;
        link_next.mode = acs_pkg::ACS_MODE_MASK_RUN;
        // (R8) start at lowest selected channel
        link_next.chan = lowest_in_mask(mask_v, link_reg.chan);
      end
      else
      begin
        if (frame_reg.ctrl_shift[acs_pkg::CB_WRITE])
        begin
          // (R16) write bit set: control register loads
          link_next.ctrl      = frame_reg.ctrl_shift;
          // (R1) span follows range bit
          link_next.range_sel = frame_reg.ctrl_shift[acs_pkg::CB_RANGE];
        end
        unique case ({link_next.ctrl[acs_pkg::CB_RUN_EN] & frame_reg.ctrl_shift[acs_pkg::CB_WRITE],
                      link_next.ctrl[acs_pkg::CB_MASK_SEL] & frame_reg.ctrl_shift[acs_pkg::CB_WRITE],
                      frame_reg.ctrl_shift[acs_pkg::CB_WRITE]})
          3'b001:
          begin
            // (R11) other combinations end the sequence
            link_next.mode = acs_pkg::ACS_MODE_SINGLE;
            // (R6) address field picks channel
            link_next.chan = link_next.ctrl[acs_pkg::CB_ADDR_HI:acs_pkg::CB_ADDR_LO];
          end
          3'b011:
          begin
            link_next.mode = acs_pkg::ACS_MODE_MASK_LOAD;
            link_next.chan = link_next.ctrl[acs_pkg::CB_ADDR_HI:acs_pkg::CB_ADDR_LO];
          end
          3'b111:
          begin
            // (R12) address is final channel, walk from zero
            link_next.mode      = acs_pkg::ACS_MODE_CONSEC;
            link_next.last_chan = link_next.ctrl[acs_pkg::CB_ADDR_HI:acs_pkg::CB_ADDR_LO];
            link_next.chan      = acs_pkg::CHAN_ZERO;
          end
          default:
          begin
            // (R10) no write or a keep-running write: advance
            unique case (link_reg.mode)
              acs_pkg::ACS_MODE_SINGLE:
              begin
                link_next.chan = link_next.ctrl[acs_pkg::CB_ADDR_HI:acs_pkg::CB_ADDR_LO];
              end
              acs_pkg::ACS_MODE_MASK_RUN:
              begin
                // (R9) wrap to lowest after highest
                link_next.chan = next_in_mask(link_reg.mask, link_reg.chan);
              end
              acs_pkg::ACS_MODE_CONSEC:
              begin
                // (R13) restart at channel 0 after final
                link_next.chan = (link_reg.chan >= link_reg.last_chan) ? acs_pkg::CHAN_ZERO
                                                                       : link_reg.chan + 4'h1;
              end
              default:
              begin
                link_next.chan = link_reg.chan;
              end
            endcase
          end
        endcase
      end
    end
  end

  // (R7) channel advances once per completed transfer
  always_ff @(posedge sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_reg <= '{en_sync1: 1'b0, en_sync2: 1'b0, ctrl: acs_pkg::CTRL_RESET,
                    mask: acs_pkg::MASK_RESET, chan: acs_pkg::CHAN_ZERO,
                    last_chan: acs_pkg::CHAN_ZERO, mode: acs_pkg::ACS_MODE_SINGLE,
                    snap_word: 16'h0000, snap_toggle: 1'b0, range_sel: 1'b0};
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // ---------------------------------------------------------------- core side
  logic                       req;
  logic                       fresh;
  logic [acs_pkg::BUS_W-1:0]  rd_v;

  always_comb
  begin
    core_next          = core_reg;
    req                = avs_read | avs_write;
    core_next.tog_sync = {core_reg.tog_sync[1:0], link_reg.snap_toggle};
    fresh              = core_reg.tog_sync[2] ^ core_reg.tog_sync[1];
    if (fresh)
    begin
      core_next.result_word = link_reg.snap_word;
      core_next.ctrl_copy   = link_reg.ctrl;
      core_next.chan_copy   = link_reg.chan;
      core_next.last_copy   = link_reg.last_chan;
      core_next.mode_copy   = link_reg.mode;
      core_next.mask_copy   = link_reg.mask;
      core_next.frame_count = core_reg.frame_count + 16'h0001;
    end
    unique case (avs_address)
      acs_pkg::REG_CONFIG: rd_v = acs_pkg::BUS_W'(core_reg.link_enable);
      acs_pkg::REG_STATUS: rd_v = acs_pkg::BUS_W'({core_reg.last_copy, core_reg.mode_copy,
                                                   core_reg.chan_copy, core_reg.ctrl_copy});
      acs_pkg::REG_RESULT: rd_v = {core_reg.frame_count, core_reg.result_word};
      acs_pkg::REG_MASK:   rd_v = acs_pkg::BUS_W'(core_reg.mask_copy);
      default:             rd_v = '0;
    endcase
    core_next.ack         = req & ~core_reg.ack;
    core_next.waitrequest = ~(req & ~core_reg.ack);
    if (req && !core_reg.ack)
    begin
      core_next.readdata = avs_read ? rd_v : '0;
    end
    if (core_reg.ack && avs_write && (avs_address == acs_pkg::REG_CONFIG)
        && avs_byteenable[0])
    begin
      core_next.link_enable = avs_writedata[acs_pkg::CFG_LINK_EN];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_reg <= '{tog_sync: 3'h0, link_enable: acs_pkg::LINK_EN_RESET, ack: 1'b0,
                    waitrequest: 1'b1, readdata: 32'h0000_0000, result_word: 16'h0000,
                    ctrl_copy: acs_pkg::CTRL_RESET, chan_copy: acs_pkg::CHAN_ZERO,
                    last_copy: acs_pkg::CHAN_ZERO, mode_copy: 4'h1,
                    mask_copy: acs_pkg::MASK_RESET, frame_count: 16'h0000};
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign avs_readdata     = core_reg.readdata;
  assign avs_waitrequest  = core_reg.waitrequest;
  assign dout             = frame_reg.dout;
  assign dout_oe_n        = frame_reg.dout_oe_n;
  assign sar_trial        = frame_reg.trial;
  assign mux_channel      = link_reg.chan;
  assign range_single_ref = link_reg.range_sel;

endmodule
`default_nettype wire

// ### logic/acs_pkg.sv
`default_nettype none
package acs_pkg;
  localparam int unsigned CTRL_W = 12;
  localparam int unsigned RES_W  = 12;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned NCHAN  = 16;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BUS_W  = 32;
  localparam int unsigned REG_AW = 3;

  // control word bit positions, first bit received is the msb
  localparam int unsigned CB_WRITE     = 11;
  localparam int unsigned CB_RUN_EN    = 10;
  localparam int unsigned CB_ADDR_HI   = 9;
  localparam int unsigned CB_ADDR_LO   = 6;
  localparam int unsigned CB_MASK_SEL  = 3;
  localparam int unsigned CB_RANGE     = 1;
  localparam int unsigned CB_CODING    = 0;

  // transfer edge numbers, counted from the first serial clock edge
  localparam logic [3:0] EDGE_ADDR_LAST = 4'h3;
  localparam logic [3:0] EDGE_CTRL_LAST = 4'hB;
  localparam logic [3:0] EDGE_LAST      = 4'hF;

  localparam logic [RES_W-1:0]  RES_MSB    = 12'h800;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam logic [NCHAN-1:0]  MASK_RESET = 16'h0000;
  localparam logic [CHAN_W-1:0] CHAN_ZERO  = 4'h0;

  // register indices on the word-addressed slave port
  localparam logic [REG_AW-1:0] REG_CONFIG = 3'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h1;
  localparam logic [REG_AW-1:0] REG_RESULT = 3'h2;
  localparam logic [REG_AW-1:0] REG_MASK   = 3'h3;
  localparam int unsigned       CFG_LINK_EN = 0;
  localparam logic              LINK_EN_RESET = 1'b1;

  typedef enum logic [3:0] {
    ACS_MODE_SINGLE    = 4'b0001,
    ACS_MODE_MASK_LOAD = 4'b0010,
    ACS_MODE_MASK_RUN  = 4'b0100,
    ACS_MODE_CONSEC    = 4'b1000
  } acs_mode_t;
endpackage
`default_nettype wire

// ### testbench/acs_sequencer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_chk
(
  input wire logic                       core_clk,
  input wire logic                       reset_n,
  input wire logic [acs_pkg::REG_AW-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic [acs_pkg::BUS_W-1:0]  avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       sclk,
  input wire logic                       cs_n,
  input wire logic                       dout,
  input wire logic                       dout_oe_n,
  input wire logic                       comparator_above,
  input wire logic [acs_pkg::RES_W-1:0]  sar_trial,
  input wire logic [acs_pkg::CHAN_W-1:0] mux_channel,
  input wire logic                       range_single_ref
);
  logic [4:0] cnt;
  logic       abit;
  logic       st_rd;
  assign abit  = mux_channel[2'h3 - cnt[1:0]];
  assign st_rd = avs_read && !avs_waitrequest && avs_address == acs_pkg::REG_STATUS;
  // edges already seen in this frame
  always_ff @(posedge sclk or negedge reset_n or posedge cs_n)
  begin
    if (!reset_n || cs_n)
      cnt <= 5'h00;
    else if (cnt != 5'h10)
      cnt <= cnt + 5'h01;
  end
  property p_rng_stat;
    @(posedge core_clk) disable iff (!reset_n) st_rd |-> avs_readdata[1] == range_single_ref;
  endproperty
  a_rng_stat: assert property (p_rng_stat) else $error("range pin off");
  property p_ch_stat;
    @(posedge core_clk) disable iff (!reset_n) st_rd |-> avs_readdata[15:12] == mux_channel;
  endproperty
  a_ch_stat: assert property (p_ch_stat) else $error("channel pin off");
  property p_trial;
    @(posedge sclk) disable iff (!reset_n)
      (!dout_oe_n && cnt == 5'h03) |=> sar_trial == acs_pkg::RES_MSB;
  endproperty
  a_trial: assert property (p_trial) else $error("first trial wrong");
  property p_sar;
    @(posedge sclk) disable iff (!reset_n)
      (!dout_oe_n && cnt >= 5'h04 && cnt <= 5'h0E) |=>
        sar_trial[4'(5'h10 - cnt)] == $past(comparator_above) && sar_trial[4'(5'h0F - cnt)];
  endproperty
  a_sar: assert property (p_sar) else $error("trial step wrong");
  property p_bit;
    @(posedge sclk) disable iff (!reset_n)
      (!dout_oe_n && cnt >= 5'h05 && cnt <= 5'h0E) |=> dout == $past(comparator_above);
  endproperty
  a_bit: assert property (p_bit) else $error("result bit wrong");
  property p_addr;
    @(posedge sclk) disable iff (!reset_n)
      (!dout_oe_n && cnt >= 5'h01 && cnt <= 5'h03) |=> dout == $past(abit);
  endproperty
  a_addr: assert property (p_addr) else $error("address bit wrong");
  property p_chan_hold;
    @(posedge sclk) disable iff (!reset_n) (cnt >= 5'h01 && cnt <= 5'h0F) |-> $stable(mux_channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid frame");
  property p_rng_hold;
    @(posedge sclk) disable iff (!reset_n)
      (cnt >= 5'h01 && cnt <= 5'h0F) |-> $stable(range_single_ref);
  endproperty
  a_rng_hold: assert property (p_rng_hold) else $error("range moved mid frame");
  property p_oe;
    @(posedge core_clk) disable iff (!reset_n) cs_n [*2] |-> dout_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("dout driven while deselected");
  c_frame: cover property (@(posedge sclk) cnt == 5'h0F);
  c_stat: cover property (@(posedge core_clk) st_rd);
  c_top: cover property (@(posedge sclk) mux_channel == 4'hF);
endmodule
bind acs_sequencer acs_sequencer_chk u_chk
(
  .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclk(sclk), .cs_n(cs_n),
  .dout(dout), .dout_oe_n(dout_oe_n), .comparator_above(comparator_above),
  .sar_trial(sar_trial), .mux_channel(mux_channel), .range_single_ref(range_single_ref)
);
`default_nettype wire

// ### testbench/acs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module acs_host_model
(
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe_n
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #37 cs_n = 1'b0;
    for (int k = 15; k >= 0; k--)
    begin
      din = tx[k];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
      rx[k] = dout_oe_n ? 1'bx : dout;
    end
    #40 cs_n = 1'b1;
    din = ~din;
    #263;
  endtask
endmodule
`default_nettype wire

// ### testbench/adc_channel_sequencer_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_channel_sequencer_control_tb;
  typedef struct packed {logic [15:0] tx; logic [3:0] ch; logic cod; logic rng;} acs_row_t;
  logic                       core_clk = 1'b0;
  logic                       reset_n = 1'b0;
  logic [acs_pkg::REG_AW-1:0] avs_address = 3'h0;
  logic                       avs_read = 1'b0;
  logic                       avs_write = 1'b0;
  logic [acs_pkg::BUS_W-1:0]  avs_writedata = 32'h0;
  logic [acs_pkg::BUS_W-1:0]  avs_readdata;
  logic                       avs_waitrequest;
  logic                       sclk;
  logic                       cs_n;
  logic                       din;
  logic                       dout;
  logic                       dout_oe_n;
  logic                       comparator_above;
  logic [acs_pkg::RES_W-1:0]  sar_trial;
  logic [acs_pkg::CHAN_W-1:0] mux_channel;
  logic                       range_single_ref;
  logic [31:0]                rd;
  logic [15:0]                rx;
  acs_row_t                   rows [6];
  int                         n_errors = 0;
  int                         compares = 0;
  function automatic logic [11:0] vin(input logic [3:0] c);
    return {c, ~c, 4'h9};
  endfunction
  // ws = write,run; sr = mask select,range,coding
  function automatic logic [15:0] cw(input logic [1:0] ws, input logic [3:0] a, input logic [2:0] sr);
    return {ws, a, 2'b11, sr[2], 1'b0, sr[1:0], 4'h0};
  endfunction
  always #12.5 core_clk = ~core_clk;
  assign comparator_above = vin(mux_channel) >= sar_trial;
  acs_sequencer u_dut
  (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .comparator_above(comparator_above),
    .sar_trial(sar_trial), .mux_channel(mux_channel), .range_single_ref(range_single_ref)
  );
  acs_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge core_clk);
    for (int n = 0; n < 100 && avs_waitrequest !== 1'b0; n++)
      @(posedge core_clk);
    if (avs_waitrequest !== 1'b0)
      n_errors++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic run(input logic [15:0] tx, input logic [3:0] ch, input logic cod);
    logic [15:0] r;
    u_host.xfer(tx, r);
    chk({16'h0, r}, {16'h0, ch, vin(ch) ^ {cod, 11'h0}});
  endtask
  initial
  begin
    #200us;
    n_errors++;
    end_sim;
  end
  initial
  begin
    rows[0] = '{cw(2'b10, 4'h5, 3'b010), 4'h0, 1'b0, 1'b1};
    rows[1] = '{cw(2'b10, 4'hF, 3'b001), 4'h5, 1'b0, 1'b0};
    rows[2] = '{cw(2'b10, 4'h0, 3'b011), 4'hF, 1'b1, 1'b1};
    rows[3] = '{cw(2'b10, 4'h9, 3'b000), 4'h0, 1'b1, 1'b0};
    rows[4] = '{16'h0000, 4'h9, 1'b0, 1'b0};
    rows[5] = '{16'h7FF0, 4'h9, 1'b0, 1'b0};
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    u_host.xfer(16'h0000, rx);
    foreach (rows[i])
    begin
      run(rows[i].tx, rows[i].ch, rows[i].cod);
      chk({31'h0, range_single_ref}, {31'h0, rows[i].rng});
    end
    $display("single mode rows done");
    run(cw(2'b10, 4'h3, 3'b100), 4'h9, 1'b0);
    run(16'h2104, 4'h3, 1'b0);
    run(16'h0000, 4'h2, 1'b0);
    run(16'h0000, 4'h7, 1'b0);
    run(16'h0000, 4'hD, 1'b0);
    run(16'h0000, 4'h2, 1'b0);
    av(1'b0, acs_pkg::REG_RESULT, 32'h0, rd);
    chk(rd, 32'h000D_22D9);
    av(1'b1, acs_pkg::REG_MASK, 32'h0000FFFF, rd);
    av(1'b0, acs_pkg::REG_MASK, 32'h0, rd);
    chk(rd, 32'h00002084);
    run(cw(2'b11, 4'h4, 3'b010), 4'h7, 1'b0);
    run(16'h0000, 4'hD, 1'b0);
    run(cw(2'b10, 4'h6, 3'b000), 4'h2, 1'b0);
    run(16'h0000, 4'h6, 1'b0);
    $display("mask sequence done");
    // link disabled: transfer must leave channel and range alone
    av(1'b1, acs_pkg::REG_CONFIG, 32'h0, rd);
    av(1'b0, acs_pkg::REG_CONFIG, 32'h0, rd);
    chk(rd, 32'h0);
    u_host.xfer(cw(2'b10, 4'hA, 3'b010), rx);
    chk({28'h0, mux_channel}, 32'h6);
    chk({31'h0, range_single_ref}, 32'h0);
    av(1'b1, acs_pkg::REG_CONFIG, 32'h1, rd);
    av(1'b0, acs_pkg::REG_CONFIG, 32'h0, rd);
    chk(rd, 32'h1);
    u_host.xfer(16'h0000, rx);
    run(cw(2'b11, 4'hF, 3'b100), 4'h6, 1'b0);
    av(1'b0, acs_pkg::REG_STATUS, 32'h0, rd);
    chk({28'h0, rd[19:16]}, 32'h8);
    for (int c = 0; c < 17; c++)
      run(16'h0000, 4'(c), 1'b0);
    run(cw(2'b11, 4'hF, 3'b000), 4'h1, 1'b0);
    run(cw(2'b10, 4'h0, 3'b000), 4'h2, 1'b0);
    av(1'b0, acs_pkg::REG_STATUS, 32'h0, rd);
    chk({28'h0, rd[19:16]}, 32'h1);
    av(1'b1, 3'h6, 32'h12345678, rd);
    av(1'b0, 3'h6, 32'h0, rd);
    chk(rd, 32'h0);
    $display("consecutive sequence done");
    run(cw(2'b10, 4'hB, 3'b010), 4'h0, 1'b0);
    chk({27'h0, mux_channel, range_single_ref}, 32'h17);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({27'h0, mux_channel, range_single_ref}, 32'h0);
    reset_n <= 1'b1;
    av(1'b0, acs_pkg::REG_MASK, 32'h0, rd);
    chk(rd, 32'h0);
    av(1'b0, acs_pkg::REG_STATUS, 32'h0, rd);
    chk(rd, 32'h0001_0000);
    u_host.xfer(16'h0000, rx);
    run(16'h0000, 4'h0, 1'b0);
    $display("reset test done");
    end_sim;
  end
endmodule
`default_nettype wire
